/* hdl/i2cst_buf.sv */
// two-entry byte buffer with valid and ready on both sides
`timescale 1ns/100ps
module i2cst_buf #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // filling side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // draining side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  logic [WIDTH-1:0] mem [2];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic push;
  logic pop;

  // handshakes from the fill level
  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage write
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem[0] <= '0;
      mem[1] <= '0;
    end
    else if (push)
      mem[wr_ptr] <= in_data;
  end

  // pointers and fill level
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= 1'h0;
      rd_ptr <= 1'h0;
      count <= 2'h0;
    end
    else
    begin
      if (push)
        wr_ptr <= ~wr_ptr;
      if (pop)
        rd_ptr <= ~rd_ptr;
      count <= count + {1'h0, push} - {1'h0, pop};
    end
  end

  // a stalled drain keeps both words and the head word
  a_buf_stall_hold: assert property (
    @(posedge mclk) disable iff (!rst_n)
    count == 2'h2 && !out_ready |=> count == 2'h2 && $stable(out_data))
    else $error("word lost while drain stalled");
endmodule

/* hdl/i2cst_pkg.sv */
// constants, states and carriers of the slave transmitter
package i2cst_pkg;
  // status codes shown in the status register
  localparam logic [7:0] ST_OWN_READ = 8'ha8;
  localparam logic [7:0] ST_ARB_READ = 8'hb0;
  localparam logic [7:0] ST_SENT_ACK = 8'hb8;
  localparam logic [7:0] ST_SENT_NACK = 8'hc0;
  localparam logic [7:0] ST_LAST_ACK = 8'hc8;
  localparam logic [7:0] ST_NO_INFO = 8'hf8;
  localparam logic [7:0] ST_BUS_ERR = 8'h00;
  // byte framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int GC_EN_BIT = 0;
  localparam logic [6:0] GC_ADDR = 7'h00;
  // start hold time and its cycle count at the 4 ns clock
  localparam int T_HD_START_NS = 4000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int HD_START_CYC =
    (T_HD_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // software control flags
  typedef struct packed {
    logic begin_request;
    logic halt_request;
    logic ack_enable;
  } i2cst_ctrl_flags_s;
  localparam i2cst_ctrl_flags_s CTRL_RESET = 3'h0;
  // slave sequencer states
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_ADDR_ACK, S_WAIT, S_TX, S_RX_ACK, S_ERR, S_START
  } i2cst_state_e;
endpackage

/* hdl/i2cst_top.sv */
// status-driven slave transmitter of the serial bus controller
// Behaviour
// - after setup, stay idle until own address and direction arrive
// - enter transmit only when the direction bit is 1
// - own address with read sets the interrupt flag with a valid code
// - report a8 after own read address; send loaded byte
// - lost arbitration then addressed for read reports b0
// - byte sent and acknowledged reports b8; next loaded byte goes out
// - with ack enable clear, send last byte; report c0 or c8
// - reading past the last byte gets released line, all ones
// - ack enable low ignores own and general call addresses
// - setting ack enable restores recognition at once
// - flag clear in c0/c8 returns to unaddressed mode
// - general call gated by own-address bit 0 in addr_hit, but never taken for transmit
// - begin request on leaving issues a start once bus is free
// - status reads f8 while the interrupt flag is low
// - bus error code 00; halt request recovery releases and clears it
`timescale 1ns/100ps
module i2cst_top (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // bus pins, open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe,
  output logic sda_out,
  output logic sda_oe,
  // software control and status
  input wire logic [7:0] addr_match_reg,
  input wire logic ctrl_wr,
  input wire i2cst_pkg::i2cst_ctrl_flags_s ctrl_wdata,
  output i2cst_pkg::i2cst_ctrl_flags_s ctrl_flags_reg,
  input wire logic si_clr,
  output logic serial_int,
  output logic [7:0] bus_state_code_reg,
  // transmit bytes from software
  input wire logic byte_valid,
  input wire logic [7:0] byte_buffer_reg,
  output logic byte_ready,
  // master path
  input wire logic arb_lost,
  output logic start_issued
);
  i2cst_pkg::i2cst_state_e state;
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_q;
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic bus_busy;
  logic [7:0] shreg;
  logic [3:0] bit_cnt;
  logic last_byte;
  logic got_ack;
  logic arb_seen;
  logic [7:0] code;
  logic set_si;
  logic [7:0] next_code;
  logic halt_clr;
  logic start_pend;
  logic [10:0] hd_cnt;
  logic buf_valid;
  logic [7:0] buf_data;
  logic buf_take;
  logic addr_hit;

  // two-entry buffer between software and the shifter
  i2cst_buf #(.WIDTH(8)) u_buf (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(byte_valid),
    .in_data(byte_buffer_reg),
    .in_ready(byte_ready),
    .out_valid(buf_valid),
    .out_data(buf_data),
    .out_ready(buf_take)
  );

  // pin synchronisers plus one delayed copy for edges
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_q <= 1'h1;
      sda_q <= 1'h1;
    end
    else
    begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_q <= scl_sync[1];
      sda_q <= sda_sync[1];
    end
  end

  // bus events
  assign scl_rise = scl_sync[1] && !scl_q;
  assign scl_fall = !scl_sync[1] && scl_q;
  assign start_det = scl_sync[1] && scl_q && sda_q && !sda_sync[1];
  assign stop_det = scl_sync[1] && scl_q && !sda_q && sda_sync[1];

  // bus busy between start and stop, always monitored
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      bus_busy <= 1'h0;
    else if (start_det)
      bus_busy <= 1'h1;
    else if (stop_det)
      bus_busy <= 1'h0;
  end

  // address match, checked live against the ack enable flag
  // ignore when disabled
  // general call gated by bit 0
  assign addr_hit = ctrl_flags_reg.ack_enable &&
    ((shreg[7:1] == addr_match_reg[7:1]) ||
     (shreg[7:1] == i2cst_pkg::GC_ADDR &&
      addr_match_reg[i2cst_pkg::GC_EN_BIT]));

  // buffer drained when software releases a data state
  assign buf_take = (state == i2cst_pkg::S_WAIT) && !serial_int && buf_valid &&
    (code == i2cst_pkg::ST_OWN_READ || code == i2cst_pkg::ST_ARB_READ ||
     code == i2cst_pkg::ST_SENT_ACK);

  // status code and flag events
  always_comb
  begin
    set_si = 1'h0;
    next_code = code;
    halt_clr = 1'h0;
    case (state)
      i2cst_pkg::S_ADDR_ACK:
        if (scl_fall)
        begin
          set_si = 1'h1;
          next_code = arb_seen ? i2cst_pkg::ST_ARB_READ :
            i2cst_pkg::ST_OWN_READ;
        end
      i2cst_pkg::S_RX_ACK:
        if (scl_fall)
        begin
          set_si = 1'h1;
          if (!got_ack)
            next_code = i2cst_pkg::ST_SENT_NACK;
          else if (last_byte)
            next_code = i2cst_pkg::ST_LAST_ACK;
          else
            next_code = i2cst_pkg::ST_SENT_ACK;
        end
      i2cst_pkg::S_ERR:
        halt_clr = !serial_int && ctrl_flags_reg.halt_request;
      default:
        ;
    endcase
    // misplaced start or stop inside a byte
    if ((state == i2cst_pkg::S_TX || state == i2cst_pkg::S_RX_ACK ||
         state == i2cst_pkg::S_ADDR_ACK) && (start_det || stop_det))
    begin
      set_si = 1'h1;
      next_code = i2cst_pkg::ST_BUS_ERR;
    end
  end

  // interrupt flag, a new event wins over a clear
  // flag raised with a valid code
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      serial_int <= 1'h0;
      code <= i2cst_pkg::ST_NO_INFO;
    end
    else
    begin
      if (set_si)
        serial_int <= 1'h1;
      else if (si_clr)
        serial_int <= 1'h0;
      code <= next_code;
    end
  end

  // no information while the flag is low
  assign bus_state_code_reg = serial_int ? code : i2cst_pkg::ST_NO_INFO;

  // control flags, software writes and hardware clears halt
  // software keeps halt request low when servicing
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_flags_reg <= i2cst_pkg::CTRL_RESET;
    else if (ctrl_wr)
      ctrl_flags_reg <= ctrl_wdata;
    else if (halt_clr)
      ctrl_flags_reg.halt_request <= 1'h0;
  end

  // remembers an arbitration loss until the sequencer is in S_WAIT or S_IDLE
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      arb_seen <= 1'h0;
    else if (arb_lost)
      arb_seen <= 1'h1;
    else if (state == i2cst_pkg::S_WAIT || state == i2cst_pkg::S_IDLE)
      arb_seen <= 1'h0;
  end

  // slave sequencer
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= i2cst_pkg::S_IDLE;
      shreg <= 8'h00;
      bit_cnt <= 4'h0;
      last_byte <= 1'h0;
      got_ack <= 1'h0;
      start_pend <= 1'h0;
      hd_cnt <= 11'h000;
      start_issued <= 1'h0;
    end
    else
    begin
      start_issued <= 1'h0;
      case (state)
        // wait for a start and the address byte
        // unaddressed: released line, master reads ones
        i2cst_pkg::S_IDLE:
          if (start_det)
          begin
            state <= i2cst_pkg::S_ADDR;
            bit_cnt <= 4'h0;
          end
          // start once the bus is free
          else if (start_pend && !bus_busy)
          begin
            state <= i2cst_pkg::S_START;
            hd_cnt <= 11'(i2cst_pkg::HD_START_CYC);
          end
        i2cst_pkg::S_ADDR:
          if (start_det)
            bit_cnt <= 4'h0;
          else if (stop_det)
            state <= i2cst_pkg::S_IDLE;
          else if (scl_rise && bit_cnt != i2cst_pkg::BITS_PER_BYTE)
          begin
            shreg <= {shreg[6:0], sda_sync[1]};
            bit_cnt <= bit_cnt + 4'h1;
          end
          // only own address with read bit
          else if (scl_fall && bit_cnt == i2cst_pkg::BITS_PER_BYTE)
            state <= (addr_hit && shreg[0] &&
              shreg[7:1] == addr_match_reg[7:1]) ?
              i2cst_pkg::S_ADDR_ACK : i2cst_pkg::S_IDLE;
        i2cst_pkg::S_ADDR_ACK:
          if (start_det || stop_det)
            state <= i2cst_pkg::S_ERR;
          else if (scl_fall)
            state <= i2cst_pkg::S_WAIT;
        i2cst_pkg::S_WAIT:
          if (!serial_int)
          begin
            // load byte, note whether it is the last
            if (buf_take)
            begin
              shreg <= buf_data;
              bit_cnt <= 4'h0;
              last_byte <= !ctrl_flags_reg.ack_enable;
              state <= i2cst_pkg::S_TX;
            end
            // leave addressed mode after c0 or c8
            else if (code == i2cst_pkg::ST_SENT_NACK ||
                     code == i2cst_pkg::ST_LAST_ACK)
            begin
              start_pend <= ctrl_flags_reg.begin_request;
              state <= i2cst_pkg::S_IDLE;
            end
          end
        // msb first, shifted on falling clock
        i2cst_pkg::S_TX:
          if (start_det || stop_det)
            state <= i2cst_pkg::S_ERR;
          else if (scl_fall)
          begin
            if (bit_cnt == i2cst_pkg::BITS_PER_BYTE - 4'h1)
              state <= i2cst_pkg::S_RX_ACK;
            shreg <= {shreg[6:0], 1'h1};
            bit_cnt <= bit_cnt + 4'h1;
          end
        i2cst_pkg::S_RX_ACK:
          if (start_det || stop_det)
            state <= i2cst_pkg::S_ERR;
          else if (scl_rise)
            got_ack <= !sda_sync[1];
          else if (scl_fall)
            state <= i2cst_pkg::S_WAIT;
        i2cst_pkg::S_ERR:
          if (halt_clr)
            state <= i2cst_pkg::S_IDLE;
        i2cst_pkg::S_START:
          if (hd_cnt == 11'h000)
          begin
            start_pend <= 1'h0;
            start_issued <= 1'h1;
            state <= i2cst_pkg::S_IDLE;
          end
          else
            hd_cnt <= hd_cnt - 11'h001;
        default:
          state <= i2cst_pkg::S_IDLE;
      endcase
    end
  end

  // pin drives: only ever pull low
  assign sda_out = 1'h0;
  assign scl_out = 1'h0;
  assign sda_oe = (state == i2cst_pkg::S_ADDR_ACK) ||
    (state == i2cst_pkg::S_START) ||
    ((state == i2cst_pkg::S_TX) && !shreg[7]);
  // clock stretched while software services the flag
  assign scl_oe = (state == i2cst_pkg::S_WAIT) && !scl_sync[1] &&
    (serial_int || !buf_take);

  a_status_no_info: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !serial_int |-> bus_state_code_reg == 8'hf8)
    else $error("status not f8 while flag low");
  a_read_gets_a8: assert property (
    @(posedge mclk) disable iff (!rst_n)
    state == i2cst_pkg::S_ADDR_ACK && scl_fall && !arb_seen && !start_det
    && !stop_det |=> serial_int && bus_state_code_reg == 8'ha8)
    else $error("own read not reported as a8");
  a_arb_gets_b0: assert property (
    @(posedge mclk) disable iff (!rst_n)
    state == i2cst_pkg::S_ADDR_ACK && scl_fall && arb_seen && !start_det
    && !stop_det |=> bus_state_code_reg == 8'hb0)
    else $error("arbitration case not b0");
  a_nack_gets_c0: assert property (
    @(posedge mclk) disable iff (!rst_n)
    state == i2cst_pkg::S_RX_ACK && scl_fall && !got_ack && !start_det
    && !stop_det |=> code == 8'hc0)
    else $error("nack not reported as c0");
  a_ack_next_code: assert property (
    @(posedge mclk) disable iff (!rst_n)
    state == i2cst_pkg::S_RX_ACK && scl_fall && got_ack && !start_det
    && !stop_det |=> code == ($past(last_byte) ? 8'hc8 : 8'hb8))
    else $error("ack reply code wrong");
  a_msb_first: assert property (
    @(posedge mclk) disable iff (!rst_n)
    buf_take |=> state == i2cst_pkg::S_TX && sda_oe == !$past(buf_data[7]))
    else $error("first bit is not the msb");
  a_idle_released: assert property (
    @(posedge mclk) disable iff (!rst_n)
    state == i2cst_pkg::S_IDLE |-> !sda_oe ##1 (state inside
      {i2cst_pkg::S_IDLE, i2cst_pkg::S_ADDR, i2cst_pkg::S_START}))
    else $error("unaddressed sequencer drove or left idle wrongly");
  a_disabled_ignores: assert property (
    @(posedge mclk) disable iff (!rst_n)
    state == i2cst_pkg::S_ADDR && !ctrl_flags_reg.ack_enable
    |=> state != i2cst_pkg::S_ADDR_ACK)
    else $error("address taken while ack enable low");
  a_leave_unaddr: assert property (
    @(posedge mclk) disable iff (!rst_n)
    state == i2cst_pkg::S_WAIT && !serial_int && code == 8'hc8
    |=> state == i2cst_pkg::S_IDLE)
    else $error("did not leave after c8");
  a_error_recover: assert property (
    @(posedge mclk) disable iff (!rst_n)
    halt_clr && !ctrl_wr |=> !ctrl_flags_reg.halt_request
    && state == i2cst_pkg::S_IDLE)
    else $error("bus error recovery failed");
endmodule

/* tb/i2cst_master.sv */
// behavioural bus master receiver that faces the slave transmitter
`timescale 1ns/100ps
module i2cst_master (
  // wire levels
  input wire logic scl,
  input wire logic sda,
  // open-drain pulls, high pulls the wire low
  output logic scl_low,
  output logic sda_low
);
  localparam time HALF = 40;
  // clock releases that never saw the wire rise
  int stalls;
  // bus released at time zero
  initial
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    stalls = 0;
  end
  // release the clock, bounded wait while the slave stretches it
  task automatic rise();
    int n;
    scl_low = 1'b0;
    n = 0;
    while (scl !== 1'b1 && n < 5000)
    begin
      #4;
      n++;
    end
    if (scl !== 1'b1)
      stalls++;
    #HALF;
  endtask
  // one bit with sda set while the clock is low; clock left high
  task automatic bit_out(input logic b);
    scl_low = 1'b1;
    #10;
    sda_low = ~b;
    #HALF;
    rise();
  endtask
  // start from an idle bus
  task automatic start();
    sda_low = 1'b1;
    #HALF;
    scl_low = 1'b1;
  endtask
  // stop: sda rises while the clock is high
  task automatic stop();
    bit_out(1'b0);
    sda_low = 1'b0;
    #HALF;
  endtask
  // address byte; ack low means acknowledged; clock left low
  // direction bit is the byte's lsb
  task automatic send_addr(input logic [7:0] a, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_out(a[i]);
    bit_out(1'b1);
    ack = sda;
    scl_low = 1'b1;
  endtask
  // data byte msb first, then acknowledge or not; clock left low
  task automatic read_byte(input logic nack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--)
    begin
      bit_out(1'b1);
      d[i] = sda;
    end
    bit_out(nack);
    scl_low = 1'b1;
    #10;
    sda_low = 1'b0;
  endtask
  // start in mid-byte, a misplaced condition
  task automatic bad_start();
    bit_out(1'b1);
    bit_out(1'b1);
    sda_low = 1'b1;
    #HALF;
  endtask
endmodule

/* tb/i2cst_tb_top.sv */
// self-checking bench of the slave transmitter
`timescale 1ns/100ps
module i2cst_tb_top;
  logic mclk;
  logic rst_n;
  logic ctrl_wr;
  i2cst_pkg::i2cst_ctrl_flags_s ctrl_wdata;
  i2cst_pkg::i2cst_ctrl_flags_s ctrl_flags_reg;
  logic si_clr, serial_int, byte_valid, byte_ready, arb_lost, start_issued;
  logic scl_out, scl_oe, sda_out, sda_oe, m_scl_low, m_sda_low, ack;
  logic [7:0] code, tx_byte, rd;
  int miscompares, checks_done, n;
  // wired-and bus with pull-ups
  wire scl = ~((scl_oe & ~scl_out) | m_scl_low);
  wire sda = ~((sda_oe & ~sda_out) | m_sda_low);

  i2cst_top i_dut (
    .mclk(mclk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_match_reg(8'h55), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata), .ctrl_flags_reg(ctrl_flags_reg),
    .si_clr(si_clr), .serial_int(serial_int),
    .bus_state_code_reg(code), .byte_valid(byte_valid),
    .byte_buffer_reg(tx_byte), .byte_ready(byte_ready),
    .arb_lost(arb_lost), .start_issued(start_issued)
  );
  i2cst_master i_master (
    .scl(scl), .sda(sda), .scl_low(m_scl_low), .sda_low(m_sda_low)
  );

  // clock
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // comparison and report
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // software accesses, one cycle each
  task automatic wr_ctrl(input logic [2:0] v);
    @(negedge mclk);
    ctrl_wr = 1'b1;
    ctrl_wdata = v;
    @(negedge mclk);
    ctrl_wr = 1'b0;
  endtask
  task automatic si_clear();
    @(negedge mclk);
    si_clr = 1'b1;
    @(negedge mclk);
    si_clr = 1'b0;
  endtask
  // byte held until the buffer shows room at a rising edge
  task automatic load(input logic [7:0] d);
    int k;
    @(negedge mclk);
    byte_valid = 1'b1;
    tx_byte = d;
    k = 0;
    while (byte_ready !== 1'b1 && k < 400)
    begin
      @(negedge mclk);
      k++;
    end
    if (byte_ready !== 1'b1)
    begin
      miscompares++;
      tally_and_finish();
    end
    @(negedge mclk);
    byte_valid = 1'b0;
  endtask
  // bounded wait for the flag, then the status code
  task automatic wait_si(input logic [7:0] exp);
    n = 0;
    while (serial_int !== 1'b1 && n < 400)
    begin
      @(negedge mclk);
      n++;
    end
    if (serial_int !== 1'b1)
    begin
      miscompares++;
      tally_and_finish();
    end
    else
      chk("code", exp, code);
  endtask

  // hang guard
  initial
  begin
    #400000;
    miscompares++;
    tally_and_finish();
  end

  // main sequence
  initial
  begin
    rst_n = 1'b0;
    ctrl_wr = 1'b0;
    ctrl_wdata = 3'h0;
    si_clr = 1'b0;
    byte_valid = 1'b0;
    tx_byte = 8'h00;
    arb_lost = 1'b0;
    miscompares = 0;
    checks_done = 0;
    repeat (8) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    chk("code", 8'hf8, code);
    chk("flags", 8'h00, {5'h0, ctrl_flags_reg});
    chk("oe", 8'h00, {6'h0, scl_oe, sda_oe});
    $display("test reset done");
    // ack enable low: own read address ignored
    i_master.start();
    i_master.send_addr(8'h55, ack);
    chk("nack", 8'h01, {7'h0, ack});
    i_master.stop();
    chk("flag", 8'h00, {7'h0, serial_int});
    // recognition back, write direction refused
    wr_ctrl(3'b001);
    i_master.start();
    i_master.send_addr(8'h54, ack);
    chk("nack", 8'h01, {7'h0, ack});
    i_master.stop();
    chk("flag", 8'h00, {7'h0, serial_int});
    $display("test ignore done");
    // two bytes fill the buffer, then a read run
    load(8'ha5);
    load(8'h3c);
    chk("ready", 8'h00, {7'h0, byte_ready});
    i_master.start();
    i_master.send_addr(8'h55, ack);
    chk("ack", 8'h00, {7'h0, ack});
    wait_si(8'ha8);
    si_clear();
    i_master.read_byte(1'b0, rd);
    chk("data", 8'ha5, rd);
    wait_si(8'hb8);
    wr_ctrl(3'b000);
    si_clear();
    i_master.read_byte(1'b0, rd);
    chk("data", 8'h3c, rd);
    wait_si(8'hc8);
    chk("ready", 8'h01, {7'h0, byte_ready});
    si_clear();
    i_master.read_byte(1'b0, rd);
    chk("data", 8'hff, rd);
    chk("flag", 8'h00, {7'h0, serial_int});
    i_master.stop();
    $display("test read run done");
    // misplaced start mid-byte, then recovery
    wr_ctrl(3'b001);
    load(8'hff);
    i_master.start();
    i_master.send_addr(8'h55, ack);
    wait_si(8'ha8);
    si_clear();
    i_master.bad_start();
    wait_si(8'h00);
    wr_ctrl(3'b011);
    si_clear();
    repeat (3) @(negedge mclk);
    chk("flags", 8'h01, {5'h0, ctrl_flags_reg});
    chk("oe", 8'h00, {6'h0, scl_oe, sda_oe});
    i_master.stop();
    $display("test bus error done");
    // lost arbitration, last byte refused, start on free bus
    load(8'h81);
    @(negedge mclk);
    arb_lost = 1'b1;
    i_master.start();
    i_master.send_addr(8'h55, ack);
    @(negedge mclk);
    arb_lost = 1'b0;
    wait_si(8'hb0);
    si_clear();
    i_master.read_byte(1'b1, rd);
    chk("data", 8'h81, rd);
    wait_si(8'hc0);
    wr_ctrl(3'b101);
    si_clear();
    i_master.stop();
    n = 0;
    while (start_issued !== 1'b1 && n < 1200)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("start", 8'h01, {7'h0, start_issued});
    $display("test arbitration done");
    chk("stall", 8'h00, {7'h0, i_master.stalls != 0});
    tally_and_finish();
  end
endmodule
